// ===== common/scc_defs.vh
/*
  Shared constants of the serial cursor controller: clock and time
  figures, register offsets, field positions, serial character layout
  and cross sizes. Included by every design file of the block.
*/
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define SCC_CLK_KHZ       50000
`define SCC_BAUD          2400
`define SCC_BIT_CYC       ((`SCC_CLK_KHZ * 1000) / `SCC_BAUD)
`define SCC_BLINK_HALF_MS 500
`define SCC_BLINK_CYC     (`SCC_BLINK_HALF_MS * `SCC_CLK_KHZ)

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SCC_REG_CTRL   3'h0
`define SCC_REG_EVT    3'h1
`define SCC_REG_POS0   3'h2
`define SCC_REG_FLAG0  3'h3
`define SCC_REG_POS1   3'h4
`define SCC_REG_FLAG1  3'h5
`define SCC_REG_LAST   3'h5
`define SCC_CTL_IRQEN  0
`define SCC_FL_SHOW    0
`define SCC_FL_FLASH   1
`define SCC_FL_FOLLOW  2
`define SCC_POS_X_LSB  0
`define SCC_POS_Y_LSB  16
`define SCC_RESP_OKAY  2'b00
`define SCC_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// Serial character layout
// ----------------------------------------------------------------
`define SCC_CH_KIND    7
`define SCC_CH_RIGHT   0
`define SCC_CH_LEFT    1
`define SCC_CH_UP      2
`define SCC_CH_DOWN    3
`define SCC_CH_VIS     0
`define SCC_CH_BLINK   1
`define SCC_CH_ENTER   2
`define SCC_CH_TRACK   3

// ----------------------------------------------------------------
// Display formats and cross arm lengths
// ----------------------------------------------------------------
`define SCC_FMT_LO320  2'b00
`define SCC_FMT_LO640  2'b01
`define SCC_FMT_HI640  2'b10
`define SCC_ARM_SHORT  10'h004
`define SCC_ARM_LONG   10'h008

`endif

// ===== core/scc_uart_rx.v
/*
  Asynchronous serial receiver, 8 data bits, one stop bit, no parity.
  Assumes an idle-high line from outside the clock domain.
*/
`timescale 1ns/1ps
`include "scc_defs.vh"
module scc_uart_rx #(
  parameter [15:0] BIT_CYC = `SCC_BIT_CYC
) (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       rxd,
  output reg  [7:0] data,
  output reg        valid
);
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_START = 2'd1;
  localparam [1:0] ST_DATA  = 2'd2;
  localparam [1:0] ST_STOP  = 2'd3;

  reg        sync_a;
  reg        sync_b;
  reg [1:0]  state;
  reg [15:0] cnt;
  reg [2:0]  bitn;

  // ----------------------------------------------------------------
  // Receive sequencer
  // ----------------------------------------------------------------
  // Sampling at mid bit gives the widest margin against baud drift.
  always @(posedge aclk) begin
    sync_a <= rxd;
    sync_b <= sync_a;
    valid  <= 1'b0;
    if (!aresetn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      state  <= ST_IDLE;
      cnt    <= 16'h0000;
      bitn   <= 3'h0;
      data   <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= {1'b0, BIT_CYC[15:1]};
          if (!sync_b) state <= ST_START;
        end
        ST_START: begin
          if (cnt != 16'h0000) cnt <= cnt - 16'h0001;
          else if (sync_b) state <= ST_IDLE;
          else begin
            cnt   <= BIT_CYC - 16'h0001;
            bitn  <= 3'h0;
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (cnt != 16'h0000) cnt <= cnt - 16'h0001;
          else begin
            cnt  <= BIT_CYC - 16'h0001;
            data <= {sync_b, data[7:1]};
            bitn <= bitn + 3'h1;
            if (bitn == 3'h7) state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (cnt != 16'h0000) cnt <= cnt - 16'h0001;
          else begin
            valid <= sync_b;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== core/scc_top.v
/*
  Cursor generator of one serial link card: two cursors, serial
  command input, AXI4-Lite register access and cursor video overlay.
  Assumes the raster position and format come from logic on aclk.
*/
`timescale 1ns/1ps
`include "scc_defs.vh"
module scc_top #(
  parameter [9:0]  H_TOTAL   = 10'd800,
  parameter [9:0]  V_TOTAL   = 10'd525,
  parameter [15:0] BIT_CYC   = `SCC_BIT_CYC,
  parameter [24:0] BLINK_CYC = `SCC_BLINK_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [31:0] araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire [1:0]  ser_rx,
  input  wire [9:0]  pix_x,
  input  wire [9:0]  pix_y,
  input  wire [1:0]  disp_fmt,
  output reg         cursor_video,
  output reg         cursor_irq
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [9:0] wrap_step;
    input [9:0] v;
    input [9:0] tot;
    input       inc;
    input       dec;
    begin
      wrap_step = v;
      if (inc && !dec)
        wrap_step = (v >= tot - 10'd1) ? 10'h000 : v + 10'd1;
      else if (dec && !inc)
        wrap_step = (v == 10'h000) ? tot - 10'd1 : v - 10'd1;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k]) merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  function [9:0] absd;
    input [9:0] a;
    input [9:0] b;
    begin
      absd = (a >= b) ? a - b : b - a;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [9:0]  cx [0:1];
  reg  [9:0]  cy [0:1];
  reg  [2:0]  flg [0:1];
  reg  [1:0]  enter_prev;
  reg         irq_en;
  reg  [3:0]  evt;
  reg  [24:0] blink_cnt;
  reg         blink_ph;
  reg  [2:0]  wr_idx;
  reg  [9:0]  next_cx [0:1];
  reg  [9:0]  next_cy [0:1];
  reg  [2:0]  next_flg [0:1];
  reg  [3:0]  evt_set;
  reg  [31:0] pos_w;
  reg  [31:0] rd_mux;
  reg  [9:0]  arm_h;
  reg  [9:0]  arm_v;
  reg         hit;
  wire [7:0]  rx_dat [0:1];
  wire [1:0]  rx_vld;
  wire        wr_take;
  wire [2:0]  aw_idx;
  wire [2:0]  ar_idx;
  integer     i;
  integer     j;
  integer     n;

  // One receiver per cursor: each cursor has its own serial line.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : rxs
      scc_uart_rx #(
        .BIT_CYC (BIT_CYC)
      ) u_rx (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rxd     (ser_rx[g]),
        .data    (rx_dat[g]),
        .valid   (rx_vld[g])
      );
    end
  endgenerate

  // Writes outside the decoded window are refused and must not alias.
  assign wr_take = awready && (awaddr[31:5] == 27'h0);
  assign aw_idx  = awaddr[4:2];
  assign ar_idx  = araddr[4:2];

  // ----------------------------------------------------------------
  // Next cursor state
  // ----------------------------------------------------------------
  // A host write in the same cycle as a serial step wins; the step is
  // dropped rather than applied to a value the host just replaced.
  always @* begin
    evt_set = 4'h0;
    pos_w   = 32'h0000_0000;
    for (i = 0; i < 2; i = i + 1) begin
      next_cx[i]  = cx[i];
      next_cy[i]  = cy[i];
      next_flg[i] = flg[i];
      if (rx_vld[i]) begin
        if (!rx_dat[i][`SCC_CH_KIND]) begin
          next_cx[i] = wrap_step(cx[i], H_TOTAL,
                         rx_dat[i][`SCC_CH_RIGHT],
                         rx_dat[i][`SCC_CH_LEFT]);
          next_cy[i] = wrap_step(cy[i], V_TOTAL,
                         rx_dat[i][`SCC_CH_DOWN],
                         rx_dat[i][`SCC_CH_UP]);
        end else begin
          next_flg[i][`SCC_FL_SHOW]   = rx_dat[i][`SCC_CH_VIS];
          next_flg[i][`SCC_FL_FLASH]  = rx_dat[i][`SCC_CH_BLINK];
          next_flg[i][`SCC_FL_FOLLOW] = rx_dat[i][`SCC_CH_TRACK];
          if (rx_dat[i][`SCC_CH_ENTER] && !enter_prev[i])
            evt_set[2*i] = 1'b1;
        end
      end
      if (wr_take && wr_idx == `SCC_REG_POS0 + 3'd2 * i[2:0]) begin
        pos_w = merge({6'h00, cy[i], 6'h00, cx[i]}, wdata, wstrb);
        next_cx[i] = pos_w[`SCC_POS_X_LSB +: 10];
        next_cy[i] = pos_w[`SCC_POS_Y_LSB +: 10];
      end
      if (wr_take && wr_idx == `SCC_REG_FLAG0 + 3'd2 * i[2:0] && wstrb[0])
        next_flg[i] = wdata[2:0];
      if (flg[i][`SCC_FL_FOLLOW] &&
          (next_cx[i] != cx[i] || next_cy[i] != cy[i]))
        evt_set[2*i+1] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  always @* begin
    case (ar_idx)
      `SCC_REG_CTRL:  rd_mux = {31'h0, irq_en};
      `SCC_REG_EVT:   rd_mux = {28'h0, evt};
      `SCC_REG_POS0:  rd_mux = {6'h00, cy[0], 6'h00, cx[0]};
      `SCC_REG_FLAG0: rd_mux = {29'h0, flg[0]};
      `SCC_REG_POS1:  rd_mux = {6'h00, cy[1], 6'h00, cx[1]};
      `SCC_REG_FLAG1: rd_mux = {29'h0, flg[1]};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `SCC_RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= `SCC_RESP_OKAY;
      rdata   <= 32'h0000_0000;
      wr_idx  <= 3'h0;
    end else begin
      if (awready) begin
        awready <= 1'b0;
        wready  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (awaddr[31:5] == 27'h0 && wr_idx <= `SCC_REG_LAST)
                   ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
      end else if (awvalid && wvalid && !bvalid) begin
        awready <= 1'b1;
        wready  <= 1'b1;
        wr_idx  <= aw_idx;
      end
      if (bvalid && bready) bvalid <= 1'b0;
      if (arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= (araddr[31:5] == 27'h0) ? rd_mux : 32'h0000_0000;
        rresp   <= (araddr[31:5] == 27'h0 && ar_idx <= `SCC_REG_LAST)
                   ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
      end else if (arvalid && !rvalid) begin
        arready <= 1'b1;
      end
      if (rvalid && rready) rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Cursor state and events
  // ----------------------------------------------------------------
  // Event bits are write-one-to-clear, and a new event in the clearing
  // cycle survives the clear.
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (n = 0; n < 2; n = n + 1) begin
        cx[n]  <= 10'h000;
        cy[n]  <= 10'h000;
        flg[n] <= 3'h0;
      end
      enter_prev <= 2'b00;
      irq_en     <= 1'b0;
      evt        <= 4'h0;
      cursor_irq <= 1'b0;
    end else begin
      for (n = 0; n < 2; n = n + 1) begin
        cx[n]  <= next_cx[n];
        cy[n]  <= next_cy[n];
        flg[n] <= next_flg[n];
        if (rx_vld[n] && rx_dat[n][`SCC_CH_KIND])
          enter_prev[n] <= rx_dat[n][`SCC_CH_ENTER];
      end
      if (wr_take && wr_idx == `SCC_REG_CTRL && wstrb[0])
        irq_en <= wdata[`SCC_CTL_IRQEN];
      if (wr_take && wr_idx == `SCC_REG_EVT && wstrb[0])
        evt <= (evt & ~wdata[3:0]) | evt_set;
      else
        evt <= evt | evt_set;
      cursor_irq <= irq_en && (evt != 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // Flash timebase
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt <= 25'h0;
      blink_ph  <= 1'b1;
    end else if (blink_cnt >= BLINK_CYC - 25'd1) begin
      blink_cnt <= 25'h0;
      blink_ph  <= ~blink_ph;
    end else begin
      blink_cnt <= blink_cnt + 25'd1;
    end
  end

  // ----------------------------------------------------------------
  // Cross drawing
  // ----------------------------------------------------------------
  // Arms double along an axis whose count doubles, so the cross keeps
  // its physical size on the same monitor.
  always @* begin
    case (disp_fmt)
      `SCC_FMT_LO320: begin
        arm_h = `SCC_ARM_SHORT;
        arm_v = `SCC_ARM_SHORT;
      end
      `SCC_FMT_LO640: begin
        arm_h = `SCC_ARM_LONG;
        arm_v = `SCC_ARM_SHORT;
      end
      default: begin
        arm_h = `SCC_ARM_LONG;
        arm_v = `SCC_ARM_LONG;
      end
    endcase
    hit = 1'b0;
    for (j = 0; j < 2; j = j + 1)
      if (flg[j][`SCC_FL_SHOW] &&
          (!flg[j][`SCC_FL_FLASH] || blink_ph) &&
          (((pix_y == cy[j]) && (pix_x != cx[j]) &&
            (absd(pix_x, cx[j]) <= arm_h)) ||
           ((pix_x == cx[j]) && (pix_y != cy[j]) &&
            (absd(pix_y, cy[j]) <= arm_v))))
        hit = 1'b1;
  end

  always @(posedge aclk) begin
    if (!aresetn)
      cursor_video <= 1'b0;
    else
      cursor_video <= hit;
  end
endmodule

// ===== tb/scc_top_chk.sv
/*
  Bus and reset checker of the cursor generator, bound to scc_top.
  Assumes scc_defs.vh is on the include path.
*/
`timescale 1ns/1ps
`include "scc_defs.vh"
module scc_top_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire [31:0] awaddr,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire [31:0] araddr,
  input wire        arready,
  input wire [31:0] rdata,
  input wire [1:0]  rresp,
  input wire        rvalid,
  input wire        rready,
  input wire        cursor_video,
  input wire        cursor_irq
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  wire bad_w = awaddr[31:5] != 27'h0 || awaddr[4:2] > `SCC_REG_LAST;
  wire bad_r = araddr[31:5] != 27'h0 || araddr[4:2] > `SCC_REG_LAST;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_w_pair_a: assert property (
    awready |-> wready && awvalid && wvalid && !bvalid)
    else $error("write taken without both channels");
  wr_resp_a: assert property (
    awready |=> bvalid && !awready)
    else $error("write response late");
  rd_resp_a: assert property (
    arready |=> rvalid && !arready)
    else $error("read response late");
  b_done_a: assert property (
    bvalid && bready |=> !bvalid)
    else $error("write response not retired");
  r_done_a: assert property (
    rvalid && rready |=> !rvalid)
    else $error("read response not retired");
  bad_wr_a: assert property (
    awready && bad_w |=> bresp == `SCC_RESP_SLVERR)
    else $error("unmapped write not refused");
  good_wr_a: assert property (
    awready && !bad_w |=> bresp == `SCC_RESP_OKAY)
    else $error("mapped write refused");
  bad_rd_a: assert property (
    arready && bad_r |=> rresp == `SCC_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  // ----------------------------------------------------------------
  // Reset
  // ----------------------------------------------------------------
  rst_quiet_a: assert property (disable iff (1'b0)
    !aresetn |=> !cursor_irq && !cursor_video && !bvalid && !rvalid)
    else $error("outputs active after reset");
endmodule
bind scc_top scc_top_chk chk (.aclk(aclk), .aresetn(aresetn),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .cursor_video(cursor_video), .cursor_irq(cursor_irq));

// ===== tb/scc_ser_tx.sv
/*
  Serial cursor controller model: sends one 8N1 character on request.
  Assumes go is held until busy rises and sel is steady while busy.
*/
`timescale 1ns/1ps
module scc_ser_tx #(
  parameter int BIT = 16
) (
  input  wire       aclk,
  input  wire       go,
  input  wire [7:0] chr,
  input  wire [1:0] sel,
  output wire [1:0] txd,
  output reg        busy
);
  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  reg       line = 1'b1;
  reg [9:0] fr;
  initial busy = 1'b0;
  // Deselected channels sit at the idle mark level.
  assign txd = ~sel | {2{line}};
  // Only step or status characters leave, one per change.
  // A character is one single step and silence is no move, so pacing,
  // direction and the dead zone are left to the calling stimulus.
  always @(posedge aclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      fr = {1'b1, chr, 1'b0};
      for (int i = 0; i < 10; i++) begin
        line <= fr[i];
        repeat (BIT) @(posedge aclk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// ===== tb/testbench.sv
/*
  Self-checking bench of the cursor generator: bus master tasks, a
  serial partner and video probes. Assumes scc_top and its checker.
*/
`timescale 1ns/1ps
`include "scc_defs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, (g), (e)); end end
module testbench;
  typedef struct packed {
    logic [7:0]  c;
    logic [31:0] a;
    logic [31:0] e;
  } scc_row_t;
  localparam [31:0] A_CTRL = 32'h0, A_EVT = 32'h4, A_POS0 = 32'h8;
  localparam [31:0] A_FLAG0 = 32'hc, A_POS1 = 32'h10, A_FLAG1 = 32'h14;
  localparam [1:0]  OK = `SCC_RESP_OKAY, ERR = `SCC_RESP_SLVERR;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, go = 1'b0;
  logic [9:0]  pix_x = 10'h0, pix_y = 10'h0;
  logic [1:0]  disp_fmt = `SCC_FMT_LO320, sel = 2'h1, ser_rx;
  logic [7:0]  chr = 8'h0;
  wire         awready, wready, bvalid, arready, rvalid, busy;
  wire         cursor_video, cursor_irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  // Stepping from 0,0 covers both wraps and the no-move pairs.
  scc_row_t rows [12] = '{
    '{8'h01, A_POS0, 32'h1}, '{8'h02, A_POS0, 32'h0},
    '{8'h02, A_POS0, 32'h31f}, '{8'h01, A_POS0, 32'h0},
    '{8'h04, A_POS0, 32'h020c0000}, '{8'h08, A_POS0, 32'h0},
    '{8'h09, A_POS0, 32'h00010001}, '{8'h03, A_POS0, 32'h00010001},
    '{8'h0c, A_POS0, 32'h00010001}, '{8'h81, A_FLAG0, 32'h1},
    '{8'h83, A_FLAG0, 32'h3}, '{8'h88, A_FLAG0, 32'h4}};
  scc_top #(.H_TOTAL(10'd800), .V_TOTAL(10'd525), .BIT_CYC(16'h10),
    .BLINK_CYC(25'd50)) dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .ser_rx(ser_rx), .pix_x(pix_x),
    .pix_y(pix_y), .disp_fmt(disp_fmt), .cursor_video(cursor_video),
    .cursor_irq(cursor_irq));
  scc_ser_tx #(.BIT(16)) ctl (.aclk(aclk), .go(go), .chr(chr),
    .sel(sel), .txd(ser_rx), .busy(busy));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input [31:0] a, input [31:0] d, input [1:0] er);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask
  task rd(input [31:0] a, input [31:0] e, input [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask
  // The receiver samples the stop bit before busy falls; the settle wait is only margin.
  task send(input [1:0] s, input [7:0] c);
    @(posedge aclk);
    sel <= s; chr <= c; go <= 1'b1;
    do @(posedge aclk); while (busy !== 1'b1);
    go <= 1'b0;
    do @(posedge aclk); while (busy !== 1'b0);
    repeat (24) @(posedge aclk);
  endtask
  task vid(input [9:0] x, input [9:0] y, input e);
    @(posedge aclk);
    pix_x <= x; pix_y <= y;
    repeat (2) @(posedge aclk);
    `CHK(cursor_video, e)
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    int cnt;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_POS0, 32'h0, OK);
    foreach (rows[i]) begin
      send(2'h1, rows[i].c);
      rd(rows[i].a, rows[i].e, OK);
    end
    wr(A_CTRL, 32'h0, OK);
    send(2'h1, 8'h01);
    rd(A_EVT, 32'h2, OK);
    `CHK(cursor_irq, 1'b0)
    wr(A_CTRL, 32'h1, OK);
    repeat (2) @(posedge aclk);
    `CHK(cursor_irq, 1'b1)
    wr(A_EVT, 32'hf, OK);
    rd(A_EVT, 32'h0, OK);
    `CHK(cursor_irq, 1'b0)
    send(2'h2, 8'h84);
    rd(A_EVT, 32'h4, OK);
    rd(A_POS0, 32'h00010002, OK);
    wr(A_EVT, 32'hf, OK);
    send(2'h2, 8'h84);
    rd(A_EVT, 32'h0, OK);
    send(2'h2, 8'h80);
    send(2'h2, 8'h84);
    rd(A_EVT, 32'h4, OK);
    wr(A_EVT, 32'hf, OK);
    wr(A_POS1, 32'h00320064, OK);
    rd(A_POS1, 32'h00320064, OK);
    wr(A_FLAG1, 32'h1, OK);
    vid(10'd100, 10'd50, 1'b0);
    vid(10'd101, 10'd50, 1'b1);
    vid(10'd100, 10'd52, 1'b1);
    vid(10'd101, 10'd51, 1'b0);
    vid(10'd106, 10'd50, 1'b0);
    disp_fmt <= `SCC_FMT_LO640;
    vid(10'd106, 10'd50, 1'b1);
    vid(10'd100, 10'd56, 1'b0);
    disp_fmt <= `SCC_FMT_HI640;
    vid(10'd106, 10'd50, 1'b1);
    vid(10'd100, 10'd56, 1'b1);
    wr(A_FLAG1, 32'h0, OK);
    vid(10'd101, 10'd50, 1'b0);
    wr(A_FLAG1, 32'h3, OK);
    cnt = 0;
    repeat (200) begin
      @(posedge aclk);
      if (cursor_video === 1'b1) cnt++;
    end
    `CHK(cnt >= 80 && cnt <= 120, 1'b1)
    rd(A_POS1, 32'h00320064, OK);
    rd(32'h18, 32'h0, ERR);
    wr(32'h18, 32'h1, ERR);
    rd(32'h20, 32'h0, ERR);
    wr(32'h20, 32'h0, ERR);
    rd(A_CTRL, 32'h1, OK);
    wstrb <= 4'h1;
    wr(A_POS1, 32'h00ff0005, OK);
    wstrb <= 4'hf;
    rd(A_POS1, 32'h00320005, OK);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_POS1, 32'h0, OK);
    rd(A_CTRL, 32'h0, OK);
    end_of_test;
  end
endmodule
